// ==== design/hbd_regs.svh ====
// Register offsets, field positions, reset values and timing figures of the bridge block
`ifndef HBD_REGS_SVH
`define HBD_REGS_SVH
// ==========================================================================
// Register map (byte addresses)
`define HBD_ADDR_CTRL       4'h0
`define HBD_ADDR_STATUS     4'h4
`define HBD_ADDR_IRQ_STAT   4'h8
`define HBD_ADDR_IRQ_MASK   4'hc
// Control fields and reset values
`define HBD_CTRL_REG_EN     0
`define HBD_CTRL_RESET      1'h1
`define HBD_MASK_RESET      4'h0
// Interrupt event bit positions
`define HBD_EV_SHORT        0
`define HBD_EV_THERMAL      1
`define HBD_EV_UNDERVOLT    2
`define HBD_EV_REGULATE     3
// Bus answers
`define HBD_RESP_OKAY       2'h0
`define HBD_RESP_SLVERR     2'h2
// ==========================================================================
// Timing, in nanoseconds, and clock period
`define HBD_CLK_NS          25
`define HBD_OFF_NS          20500
`define HBD_BLANK_NS        16500
`define HBD_MIN_PERIOD_NS   50000
`endif

// ==== design/hbd_pkg.sv ====
// Types shared by the bridge control block
`default_nettype none
package hbd_pkg;
    // Comparator and supervisor levels from the analog front end
    typedef struct packed {
        logic short_high;
        logic short_low;
        logic over_temp;
        logic under_volt;
        logic at_limit;
    } hbd_sense_t;
    // Constant-off-time regulator states
    typedef enum logic [1:0] {ST_IDLE, ST_BLANK, ST_RUN, ST_OFF} hbd_reg_state_t;
endpackage : hbd_pkg
`default_nettype wire

// ==== design/hbd_bridge.sv ====
// Full-bridge drive and protection logic with AXI4-Lite status and interrupt registers
// Function
// [R1] Host may modulate by holding one direction input high, toggling the other near 10 kHz.
// [R2] At the low-side current threshold, switch bridge off a fixed time, then re-enable.
// [R3] Bridge fully tri-stated during each off interval of 15 to 26 us, typically 20.5.
// [R4] Internal regulation switching rate never exceeds 20 kHz.
// [R5] Regulation threshold ignored for a 12 to 21 us blanking interval after activation.
// [R6] Short-circuit crossing during blanking tri-states and latches outputs off at once.
// [R7] Overtemperature tri-states and latches outputs off.
// [R8] Latches and fault flag clear only when a disable input toggles.
// [R9] Undervoltage tri-states both outputs and pulls fault flag low.
// [R10] Undervoltage recovery releases flag and restores outputs without host action.
// [R11] Enabled and not disabled, each direction input sets its own output level.
// [R12] Either disable input asserted tri-states both outputs; other logic keeps running.
// [R13] Enable low means sleep: outputs tri-stated, fault flag released high.
// [R14] Both inputs high or both low drive both outputs to one rail.
// [R15] Disable asserted also pulls fault flag low; floating pins resolve to safe levels.
// [R16] Short or thermal latch holds outputs off and flag low until disable toggles.
`include "hbd_regs.svh"
`default_nettype none
module hbd_bridge #(
    parameter int CLK_NS = `HBD_CLK_NS
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Control pins, already resolved by pad pulls
    input  wire logic               en,
    input  wire logic               dir_input_a,
    input  wire logic               dir_input_b,
    input  wire logic               disable_active_high,
    input  wire logic               disable_active_low_n,
    input  wire hbd_pkg::hbd_sense_t sense,
    // Half-bridge outputs, enables low while driving
    output logic                    bridge_output_a,
    output logic                    bridge_output_a_oe_n,
    output logic                    bridge_output_b,
    output logic                    bridge_output_b_oe_n,
    output logic                    fault_flag_n,
    output logic                    irq,
    // AXI4-Lite slave
    input  wire logic [3:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [3:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    // ======================================================================
    // Timing counts: minima round up, so off time and period never run short
    localparam int OFF_CYC   = (`HBD_OFF_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLANK_CYC = (`HBD_BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int PER_CYC   = (`HBD_MIN_PERIOD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [11:0] OFF_LAST   = 12'(OFF_CYC - 1);
    localparam logic [11:0] BLANK_LAST = 12'(BLANK_CYC - 1);
    localparam logic [11:0] PER_LAST   = 12'(PER_CYC - 1);

    hbd_pkg::hbd_reg_state_t st;
    logic [11:0] tmr;
    logic [11:0] per_cnt;
    logic        latch_short;
    logic        latch_therm;
    logic        dah_prev;
    logic        dal_prev;
    logic        dir_a_prev;
    logic        dir_b_prev;
    logic        uv_prev;
    logic        reg_en;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // ======================================================================
    // Protection decode
    logic disabled;
    logic toggle;
    logic latched;
    logic drive_base;
    logic next_drive;
    assign disabled   = disable_active_high | ~disable_active_low_n;                 // [R12]
    assign toggle     = (disable_active_high != dah_prev) | (disable_active_low_n != dal_prev); // [R8]
    assign latched    = latch_short | latch_therm;
    assign drive_base = en & ~disabled & ~latched & ~sense.under_volt;             // [R9] [R10] [R13]
    assign next_drive = drive_base & (st == hbd_pkg::ST_BLANK || st == hbd_pkg::ST_RUN); // [R3]

    // Disable pin history for toggle detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dah_prev <= 1'b1;
            dal_prev <= 1'b0;
        end else begin
            dah_prev <= disable_active_high;
            dal_prev <= disable_active_low_n;
        end
    end

    // Fault latches; a new fault in the toggle cycle wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_short <= 1'b0;
            latch_therm <= 1'b0;
        end else begin
            if (en && (sense.short_high || sense.short_low)) begin
                latch_short <= 1'b1;                                               // [R6] [R16]
            end else if (toggle) begin
                latch_short <= 1'b0;                                               // [R8]
            end
            if (en && sense.over_temp) begin
                latch_therm <= 1'b1;                                               // [R7] [R16]
            end else if (toggle) begin
                latch_therm <= 1'b0;                                               // [R8]
            end
        end
    end

    // ======================================================================
    // Constant-off-time regulator
    logic dir_change;
    logic period_ok;
    assign dir_change = (dir_input_a != dir_a_prev) | (dir_input_b != dir_b_prev);
    assign period_ok  = per_cnt >= PER_LAST;                                       // [R4]

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st  <= hbd_pkg::ST_IDLE;
            tmr <= 12'h000;
        end else if (!drive_base) begin
            st  <= hbd_pkg::ST_IDLE;
            tmr <= 12'h000;
        end else begin
            case (st)
                hbd_pkg::ST_IDLE: begin
                    st  <= hbd_pkg::ST_BLANK;                                      // [R5]
                    tmr <= 12'h000;
                end
                hbd_pkg::ST_BLANK: begin
                    if (tmr == BLANK_LAST) begin
                        st  <= hbd_pkg::ST_RUN;
                        tmr <= 12'h000;
                    end else begin
                        tmr <= tmr + 12'h001;                                      // [R5]
                    end
                end
                hbd_pkg::ST_RUN: begin
                    if (dir_change) begin
                        st  <= hbd_pkg::ST_BLANK;                                  // [R5]
                    end else if (reg_en && sense.at_limit && period_ok) begin
                        st  <= hbd_pkg::ST_OFF;                                    // [R2] [R4]
                    end
                    tmr <= 12'h000;
                end
                hbd_pkg::ST_OFF: begin
                    if (tmr == OFF_LAST) begin
                        st  <= hbd_pkg::ST_BLANK;                                  // [R2]
                        tmr <= 12'h000;
                    end else begin
                        tmr <= tmr + 12'h001;                                      // [R3]
                    end
                end
                default: begin
                    st  <= hbd_pkg::ST_IDLE;
                    tmr <= 12'h000;
                end
            endcase
        end
    end

    // Period since last off start; saturates so it cannot wrap into a short period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_cnt <= PER_LAST;
        end else if (st == hbd_pkg::ST_RUN && drive_base && !dir_change && reg_en
                     && sense.at_limit && period_ok) begin
            per_cnt <= 12'h000;                                                    // [R4]
        end else if (!period_ok) begin
            per_cnt <= per_cnt + 12'h001;
        end
    end

    // Direction history for activation detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_a_prev <= 1'b1;
            dir_b_prev <= 1'b1;
        end else begin
            dir_a_prev <= dir_input_a;
            dir_b_prev <= dir_input_b;
        end
    end

    // ======================================================================
    // Pin outputs, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bridge_output_a      <= 1'b0;
            bridge_output_b      <= 1'b0;
            bridge_output_a_oe_n <= 1'b1;
            bridge_output_b_oe_n <= 1'b1;
            fault_flag_n         <= 1'b1;
        end else begin
            bridge_output_a      <= dir_input_a;                                   // [R1] [R11] [R14]
            bridge_output_b      <= dir_input_b;                                   // [R11] [R14]
            bridge_output_a_oe_n <= ~next_drive;                                   // [R3] [R12]
            bridge_output_b_oe_n <= ~next_drive;                                   // [R3] [R12]
            fault_flag_n         <= ~(en & (disabled | latched | sense.under_volt)); // [R9] [R13] [R15]
        end
    end

    // ======================================================================
    // Interrupt status: set wins over write-one-to-clear
    logic [3:0] ev;
    logic       do_write;
    assign ev[`HBD_EV_SHORT]     = en & (sense.short_high | sense.short_low) & ~latch_short;
    assign ev[`HBD_EV_THERMAL]   = en & sense.over_temp & ~latch_therm;
    assign ev[`HBD_EV_UNDERVOLT] = sense.under_volt & ~uv_prev;
    assign ev[`HBD_EV_REGULATE]  = (st == hbd_pkg::ST_RUN) & drive_base & ~dir_change & reg_en
                                   & sense.at_limit & period_ok;
    assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            uv_prev  <= 1'b0;
            irq_stat <= 4'h0;
            irq      <= 1'b0;
        end else begin
            uv_prev <= sense.under_volt;
            if (do_write && w_strb[0] && aw_addr == `HBD_ADDR_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~w_data[3:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            irq <= |(irq_stat & irq_mask);
        end
    end

    // Software control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_en   <= `HBD_CTRL_RESET;
            irq_mask <= `HBD_MASK_RESET;
        end else if (do_write && w_strb[0]) begin
            if (aw_addr == `HBD_ADDR_CTRL) begin
                reg_en <= w_data[`HBD_CTRL_REG_EN];
            end
            if (aw_addr == `HBD_ADDR_IRQ_MASK) begin
                irq_mask <= w_data[3:0];
            end
        end
    end

    // ======================================================================
    // AXI4-Lite write path: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `HBD_RESP_OKAY;
            aw_addr       <= 4'h0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == `HBD_ADDR_STATUS) ? `HBD_RESP_OKAY
                                : (aw_addr == `HBD_ADDR_CTRL || aw_addr == `HBD_ADDR_IRQ_STAT
                                   || aw_addr == `HBD_ADDR_IRQ_MASK) ? `HBD_RESP_OKAY : `HBD_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read decode; unmapped words answer zero with an error
    function automatic logic [33:0] hbd_read(input logic [3:0] addr);
        case (addr)
            `HBD_ADDR_CTRL:     hbd_read = {`HBD_RESP_OKAY, 31'h0, reg_en};
            `HBD_ADDR_STATUS:   hbd_read = {`HBD_RESP_OKAY, 25'h0, st, sense.under_volt,
                                            latch_therm, latch_short, ~fault_flag_n, next_drive};
            `HBD_ADDR_IRQ_STAT: hbd_read = {`HBD_RESP_OKAY, 28'h0, irq_stat};
            `HBD_ADDR_IRQ_MASK: hbd_read = {`HBD_RESP_OKAY, 28'h0, irq_mask};
            default:            hbd_read = {`HBD_RESP_SLVERR, 32'h0};
        endcase
    endfunction : hbd_read

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `HBD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            {s_axi_rresp, s_axi_rdata} <= hbd_read(s_axi_araddr);
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ======================================================================
    // Checks
    a_off_tristate: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
        st == hbd_pkg::ST_OFF |=> bridge_output_a_oe_n && bridge_output_b_oe_n)
        else $error("bridge driven during off interval");
    a_off_length: assert property (@(posedge aclk) disable iff (!aresetn) // [R3] [R2]
        (st == hbd_pkg::ST_OFF && tmr < OFF_LAST && drive_base) |=> st == hbd_pkg::ST_OFF)
        else $error("off interval ended early");
    a_blank_ignore: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
        st == hbd_pkg::ST_BLANK |=> st != hbd_pkg::ST_OFF)
        else $error("regulation acted during blanking");
    a_min_period: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
        $rose(st == hbd_pkg::ST_OFF) |-> $past(per_cnt) >= PER_LAST)
        else $error("regulation period too short");
    a_short_latch: assert property (@(posedge aclk) disable iff (!aresetn) // [R6] [R16]
        (en && sense.short_low) |=> latch_short ##1 (bridge_output_a_oe_n && !fault_flag_n))
        else $error("short not latched off");
    a_latch_clear: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
        (toggle && !sense.short_high && !sense.short_low && !sense.over_temp) |=> !latched)
        else $error("toggle failed to clear latch");
    a_uv_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R9] [R10]
        (en && !disabled && !latched) |=> fault_flag_n == !$past(sense.under_volt))
        else $error("undervoltage flag wrong");
    a_sleep_state: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
        !en |=> fault_flag_n && bridge_output_a_oe_n && bridge_output_b_oe_n)
        else $error("sleep not honoured");
    a_dir_follow: assert property (@(posedge aclk) disable iff (!aresetn) // [R11] [R14]
        !bridge_output_a_oe_n |-> bridge_output_a == $past(dir_input_a)
                                  && bridge_output_b == $past(dir_input_b))
        else $error("output does not follow direction");
    a_disable_flag: assert property (@(posedge aclk) disable iff (!aresetn) // [R12] [R15]
        (en && disabled) |=> !fault_flag_n && bridge_output_a_oe_n)
        else $error("disable not honoured");
endmodule : hbd_bridge
`default_nettype wire

// ==== tb/hbd_host.sv ====
// Host controller model that drives the bridge control pins
`default_nettype none
module hbd_host (
    input  wire logic aclk,
    output logic      en,
    output logic      dir_input_a,
    output logic      dir_input_b,
    output logic      disable_active_high,
    output logic      disable_active_low_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // ======================================================================
    // Pin control
    // Start asleep and disabled, the levels that floating pins settle to
    initial begin
        en = 1'b0;
        dir_input_a = 1'b1;
        dir_input_b = 1'b1;
        disable_active_high = 1'b1;
        disable_active_low_n = 1'b0;
    end
    // One pin update, launched right after a rising edge
    task automatic set_pins(input logic e, input logic a, input logic b, input logic dh, input logic dl);
        @(posedge aclk);
        en <= e;
        dir_input_a <= a;
        dir_input_b <= b;
        disable_active_high <= dh;
        disable_active_low_n <= dl;
    endtask : set_pins
    // Open-loop modulation: first input held high, second one toggled
    task automatic pwm(input int periods, input int half);
        for (int i = 0; i < periods * 2; i++) begin
            set_pins(1'b1, 1'b1, i[0], 1'b0, 1'b1);
            repeat (half - 1) @(posedge aclk);
        end
    endtask : pwm
    // Latched faults only go away on a disable toggle, so pulse one
    task automatic clear_latch();
        set_pins(en, dir_input_a, dir_input_b, 1'b1, 1'b1);
        repeat (4) @(posedge aclk);
        set_pins(en, dir_input_a, dir_input_b, 1'b0, 1'b1);
    endtask : clear_latch
endmodule : hbd_host
`default_nettype wire

// ==== tb/hbridge_drive_fault_logic_test.sv ====
// Bench for the bridge block: pin scenarios and register accesses
`include "hbd_regs.svh"
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module hbridge_drive_fault_logic_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic en, dir_a, dir_b, dah, daln, out_a, oe_a, out_b, oe_b, fault_flag_n, irq;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    hbd_pkg::hbd_sense_t sense;
    int bad_count, samples_checked, n, m;
    // ======================================================================
    // Clock, models and device
    initial aclk = 1'b0;
    always #12.5 aclk = ~aclk;
    hbd_host hbd_host_i (.aclk(aclk), .en(en), .dir_input_a(dir_a), .dir_input_b(dir_b),
        .disable_active_high(dah), .disable_active_low_n(daln));
    hbd_bridge hbd_bridge_i (.aclk(aclk), .aresetn(aresetn), .en(en), .dir_input_a(dir_a),
        .dir_input_b(dir_b), .disable_active_high(dah), .disable_active_low_n(daln), .sense(sense),
        .bridge_output_a(out_a), .bridge_output_a_oe_n(oe_a), .bridge_output_b(out_b),
        .bridge_output_b_oe_n(oe_b), .fault_flag_n(fault_flag_n), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // ======================================================================
    // Bus and timing tasks; each bus task starts one edge on so no signal is set twice
    task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
        int k;
        @(posedge aclk);
        k = 0;
        awaddr  <= a;
        wdata   <= v;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 1000);
        resp = bresp;
        bready <= 1'b0;
        if (k >= 1000) bad_count++;
    endtask : axi_write
    task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
        int k;
        @(posedge aclk);
        k = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 1000);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (k >= 1000) bad_count++;
    endtask : axi_read
    task automatic tick(input int k);
        repeat (k) @(posedge aclk);
    endtask : tick
    // Cycles that the bridge stays at one enable level, capped
    task automatic run_len(input logic lvl, input int cap, output int cnt);
        cnt = 0;
        while (oe_a === lvl && cnt < cap) begin
            @(posedge aclk);
            cnt++;
        end
    endtask : run_len
    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // Watchdog, well beyond the roughly 15k cycles the tests need
    initial begin
        repeat (80000) @(posedge aclk);
        bad_count++;
        end_sim();
    end
    // ======================================================================
    // Tests
    initial begin
        aresetn = 1'b0;
        sense = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        tick(1);
        `CHK({oe_a, oe_b, fault_flag_n, irq}, 4'he)
        axi_read(`HBD_ADDR_CTRL, d, r);
        `CHK(d, 32'h1)
        axi_read(`HBD_ADDR_IRQ_MASK, d, r);
        `CHK(d, 32'h0)
        axi_read(4'h6, d, r);
        `CHK({r, d}, {`HBD_RESP_SLVERR, 32'h0})
        // Every direction pair, including both rails for braking
        for (int i = 0; i < 4; i++) begin
            hbd_host_i.set_pins(1'b1, i[1], i[0], 1'b0, 1'b1);
            tick(4);
            `CHK({oe_a, oe_b, fault_flag_n, out_a, out_b}, {3'h1, i[1:0]})
        end
        hbd_host_i.set_pins(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        tick(4);
        `CHK({oe_a, oe_b, fault_flag_n}, 3'h6)
        hbd_host_i.set_pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        tick(4);
        `CHK({oe_a, oe_b, fault_flag_n}, 3'h6)
        hbd_host_i.set_pins(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        tick(4);
        `CHK({oe_a, oe_b, fault_flag_n}, 3'h7)
        hbd_host_i.pwm(2, 2000);
        tick(3);
        `CHK({oe_a, oe_b, out_a, out_b}, 4'h3)
        // Undervoltage with the mask closed, then opened, then cleared
        sense.under_volt <= 1'b1;
        tick(4);
        `CHK({oe_a, oe_b, fault_flag_n, irq}, 4'hc)
        axi_read(`HBD_ADDR_STATUS, d, r);
        `CHK({r, d}, {`HBD_RESP_OKAY, 32'h12})
        axi_write(`HBD_ADDR_IRQ_MASK, 32'hf, r);
        tick(3);
        `CHK(irq, 1'b1)
        sense.under_volt <= 1'b0;
        tick(4);
        `CHK({oe_a, oe_b, fault_flag_n}, 3'h1)
        axi_write(`HBD_ADDR_IRQ_STAT, 32'h4, r);
        tick(3);
        `CHK({r, irq}, {`HBD_RESP_OKAY, 1'b0})
        // Short, then thermal: latch holds; in the short pass also through a direction change
        for (int j = 0; j < 2; j++) begin
            if (j == 0) sense.short_low <= 1'b1;
            else sense.over_temp <= 1'b1;
            tick(1);
            sense <= '0;
            tick(4);
            `CHK({oe_a, oe_b, fault_flag_n}, 3'h6)
            hbd_host_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
            tick(4);
            `CHK({oe_a, oe_b, fault_flag_n}, 3'h6)
            hbd_host_i.clear_latch();
            tick(4);
            `CHK({oe_a, oe_b, fault_flag_n, out_a, out_b}, 5'h05)
        end
        // Constant-off-time regulation with the limit held active
        hbd_host_i.set_pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
        sense.at_limit <= 1'b1;
        hbd_host_i.set_pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        // Let the disable reach the pins before timing the next drive span
        tick(1);
        run_len(1'b1, 50, n);
        run_len(1'b0, 5000, n);
        `CHK({oe_b, n >= 12000 / `HBD_CLK_NS, n <= 21000 / `HBD_CLK_NS}, 3'h7)
        run_len(1'b1, 5000, n);
        `CHK({oe_b, n >= 15000 / `HBD_CLK_NS, n <= 26000 / `HBD_CLK_NS}, 3'h3)
        run_len(1'b0, 5000, m);
        `CHK({m >= 12000 / `HBD_CLK_NS, n + m >= `HBD_MIN_PERIOD_NS / `HBD_CLK_NS}, 2'h3)
        axi_read(`HBD_ADDR_IRQ_STAT, d, r);
        `CHK(d[`HBD_EV_REGULATE], 1'b1)
        axi_write(`HBD_ADDR_CTRL, 32'h0, r);
        tick(1100);
        run_len(1'b0, 3000, n);
        `CHK(n, 3000)
        sense.at_limit <= 1'b0;
        end_sim();
    end
endmodule : hbridge_drive_fault_logic_test
`default_nettype wire
